// ==== pkg/pcr_pkg.sv ====
/*
  Shared constants, types and decode helpers for the configuration header register bank.
  Assumes configuration cycles arrive on the same clock as the bank, one dword per request.
*/
package pcr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // address geometry
  localparam int CFG_ADDR_W = 8;
  localparam int DWORD_IDX_W = 6;
  localparam int HDR_DWORDS = 16;

  // byte offsets of the decoded dwords
  localparam logic [7:0] OFF_IDENT = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_RSVD_FIRST = 8'h14;
  localparam logic [7:0] OFF_RSVD_LAST = 8'h38;
  localparam logic [7:0] OFF_INTR = 8'h3c;
  localparam logic [7:0] OFF_DEP_FIRST = 8'h40;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int LAT_LSB = 24;
  localparam int GNT_LSB = 16;
  localparam int PIN_LSB = 8;
  localparam int LINE_LSB = 0;
  localparam int ID_DEV_LSB = 16;
  localparam int STAT_FLAG_BIT = 31;
  localparam int LINE_BYTE_LANE = 0;
  localparam int FLAG_BYTE_LANE = 3;

  ////////////////////////////////////////////////////////////////////////////
  // fixed and reset values
  localparam logic [7:0] MAX_LAT_VAL = 8'h0f;
  localparam logic [7:0] MIN_GNT_VAL = 8'h00;
  localparam logic [7:0] INT_PIN_VAL = 8'h01;
  localparam logic [7:0] INT_LINE_RST = 8'h00;
  localparam logic STAT_FLAG_RST = 1'b0;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam int ANS_LAT_CYC = 1;

  typedef enum logic {
    PCR_ANS_IDLE = 1'b0,
    PCR_ANS_DONE = 1'b1
  } pcr_ans_t;

  function automatic logic [5:0] pcr_dw(input logic [7:0] off);
    return off[7:2];
  endfunction

  function automatic logic pcr_in_range(input logic [5:0] idx, input logic [7:0] lo, input logic [7:0] hi);
    return (idx >= pcr_dw(lo)) && (idx <= pcr_dw(hi));
  endfunction

endpackage

// ==== pkg/pcr_cfg_if.sv ====
/*
  Carrier between the bank top, its address decoder and its writable byte store.
  Assumes the top drives the request side already gated by the clock enable.
*/
`timescale 1ns/10ps
interface pcr_cfg_if;
  logic req;
  logic we;
  logic func;
  logic [5:0] dw;
  logic [3:0] be;
  logic [31:0] wdata;
  logic sel_id;
  logic sel_stat;
  logic sel_intr;
  logic sel_rsvd;
  logic sel_dep;

  modport host (output req, we, func, dw, be, wdata, input sel_id, sel_stat, sel_intr, sel_rsvd, sel_dep);
  modport dec (input func, dw, output sel_id, sel_stat, sel_intr, sel_rsvd, sel_dep);
  modport store (input req, we, be, wdata, sel_intr);
endinterface

// ==== core/pcr_addr_dec.sv ====
/*
  Function and dword decoder for configuration cycles.
  Assumes dw is the dword index of the byte address and func the function number.
*/
`timescale 1ns/10ps
module pcr_addr_dec
  import pcr_pkg::*;
(
  pcr_cfg_if.dec cfg
);

  always_comb begin
    cfg.sel_id = 1'b0;
    cfg.sel_stat = 1'b0;
    cfg.sel_intr = 1'b0;
    cfg.sel_rsvd = 1'b0;
    // RQ6 header limit decode
    cfg.sel_dep = (cfg.dw >= pcr_dw(OFF_DEP_FIRST));
    if (!cfg.sel_dep) begin
      // RQ13 shared identification dword
      cfg.sel_id = (cfg.dw == pcr_dw(OFF_IDENT));
      if (cfg.func) begin
        // RQ10 sixteen dword decode
        cfg.sel_stat = (cfg.dw == pcr_dw(OFF_STATUS));
      end else begin
        // RQ1 reserved span decode
        cfg.sel_rsvd = pcr_in_range(cfg.dw, OFF_RSVD_FIRST, OFF_RSVD_LAST);
        cfg.sel_intr = (cfg.dw == pcr_dw(OFF_INTR));
      end
    end
  end

endmodule

// ==== core/pcr_line_store.sv ====
/*
  Writable interrupt routing byte of the first function.
  Assumes req is already qualified by the clock enable and decode comes through the carrier.
*/
`timescale 1ns/10ps
module pcr_line_store
  import pcr_pkg::*;
(
  // clock, reset and enable
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // carrier
  pcr_cfg_if.store cfg,
  // stored value
  output logic [7:0] line_o
);

  logic [7:0] line_reg;
  logic [7:0] line_next;

  always_comb begin
    line_next = line_reg;
    // RQ9 keep last write
    if (cfg.req && cfg.we && cfg.sel_intr && cfg.be[LINE_BYTE_LANE]) begin
      line_next = cfg.wdata[LINE_LSB +: 8];
    end
  end

  // RQ5 routing byte reset
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      line_reg <= INT_LINE_RST;
    end else if (ce_i) begin
      line_reg <= line_next;
    end
  end

  assign line_o = line_reg;

endmodule

// ==== core/pcr_cfg_regs.sv ====
/*
  Configuration header register bank: tail of the first function header, identification
  dword shared by both functions, and a write-one-to-reset event flag in the second function.
  Assumes configuration cycles come from logic on mclk_i, one dword per one-cycle request.
*/
`timescale 1ns/10ps

// Notes on behaviour
// RQ1: First-function dwords 0x14 to 0x38 read as zero and ignore writes.
// RQ2: Bits 31:24 of dword 0x3c read the fixed latency requirement 0x0f and cannot be written.
// RQ3: Bits 23:16 of dword 0x3c read zero and cannot be written.
// RQ4: Bits 15:8 of dword 0x3c read 0x01, naming the first interrupt pin.
// RQ5: Bits 7:0 of dword 0x3c reset to zero and hold the routing byte software writes.
// RQ6: Only the 64-byte header exists; offsets 0x40 and above read zero and ignore writes.
// RQ7: Read-only fields return their fixed pattern, unused ones zero, and writes never change them.
// RQ8: A write-one-to-reset bit clears when a one is written to it and keeps its value on a zero.
// RQ9: A read/write field returns exactly the value last written to it.
// RQ10: The second function decodes sixteen dwords at consecutive offsets from zero.
// RQ11: Bits 31:16 of dword 0 return a fixed device code whose low digit follows the channel count.
// RQ12: Bits 15:0 of dword 0 return a fixed vendor code and ignore writes.
// RQ13: Dword 0 is one register, read the same from either function.
// RQ14: Registers are reached only by configuration cycles naming function and dword, answered in that cycle's data phase.
module pcr_cfg_regs
  import pcr_pkg::*;
#(
  parameter int CHAN_COUNT = 256,
  // arbitrary identity values, not any real part
  parameter logic [11:0] DEV_ID_HI = 12'h5a3,
  parameter logic [15:0] VENDOR_ID = 16'h0a5c
)
(
  // clock, reset, enable
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // configuration cycle request
  input wire logic cfg_req_i,
  input wire logic cfg_we_i,
  input wire logic cfg_func_i,
  input wire logic [CFG_ADDR_W-1:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  // configuration cycle answer
  output logic cfg_ack_o,
  output logic [31:0] cfg_rdata_o,
  // event flag
  input wire logic det_evt_i,
  output logic det_flag_o
);

  ////////////////////////////////////////////////////////////////////////////
  // identity word

  function automatic logic [3:0] chan_digit(input int chans);
    case (chans)
      32: return 4'h1;
      64: return 4'h2;
      128: return 4'h4;
      default: return 4'h8;
    endcase
  endfunction

  localparam logic [31:0] ID_WORD = {DEV_ID_HI, chan_digit(CHAN_COUNT), VENDOR_ID};

  ////////////////////////////////////////////////////////////////////////////
  // decode and store

  pcr_cfg_if cfg ();

  logic take;
  logic [7:0] line_val;

  // RQ14 cycle taken on enable
  assign take = cfg_req_i && ce_i;
  assign cfg.req = take;
  assign cfg.we = cfg_we_i;
  assign cfg.func = cfg_func_i;
  assign cfg.dw = cfg_addr_i[CFG_ADDR_W-1:2];
  assign cfg.be = cfg_be_i;
  assign cfg.wdata = cfg_wdata_i;

  pcr_addr_dec u_dec (
    .cfg(cfg.dec)
  );

  pcr_line_store u_line (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .cfg(cfg.store),
    .line_o(line_val)
  );

  ////////////////////////////////////////////////////////////////////////////
  // event flag

  logic flag_reg;
  logic flag_next;
  logic flag_clr;

  assign flag_clr = take && cfg_we_i && cfg.sel_stat && cfg_be_i[FLAG_BYTE_LANE] && cfg_wdata_i[STAT_FLAG_BIT];

  always_comb begin
    flag_next = flag_reg;
    // RQ8 write one resets
    if (flag_clr) begin
      flag_next = 1'b0;
    end
    // a new event in the clearing cycle survives
    if (det_evt_i) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_reg <= STAT_FLAG_RST;
    end else if (ce_i) begin
      flag_reg <= flag_next;
    end
  end

  assign det_flag_o = flag_reg;

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  logic [31:0] rd_word;

  always_comb begin
    // RQ7 unused reads zero
    rd_word = ZERO_WORD;
    if (cfg.sel_id) begin
      // RQ11 device code
      // RQ12 vendor code
      rd_word = ID_WORD;
    end else if (cfg.sel_intr) begin
      // RQ2 latency field
      rd_word[LAT_LSB +: 8] = MAX_LAT_VAL;
      // RQ3 grant field
      rd_word[GNT_LSB +: 8] = MIN_GNT_VAL;
      // RQ4 pin field
      rd_word[PIN_LSB +: 8] = INT_PIN_VAL;
      rd_word[LINE_LSB +: 8] = line_val;
    end else if (cfg.sel_stat) begin
      rd_word[STAT_FLAG_BIT] = flag_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer phase

  pcr_ans_t ans_reg;
  pcr_ans_t ans_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  always_comb begin
    ans_next = ans_reg;
    rdata_next = rdata_reg;
    case (ans_reg)
      PCR_ANS_IDLE: begin
        if (take) begin
          ans_next = PCR_ANS_DONE;
        end
      end
      PCR_ANS_DONE: begin
        if (!take) begin
          ans_next = PCR_ANS_IDLE;
        end
      end
      default: begin
        ans_next = PCR_ANS_IDLE;
      end
    endcase
    // RQ14 data phase word
    if (take) begin
      rdata_next = cfg_we_i ? ZERO_WORD : rd_word;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ans_reg <= PCR_ANS_IDLE;
      rdata_reg <= ZERO_WORD;
    end else if (ce_i) begin
      ans_reg <= ans_next;
      rdata_reg <= rdata_next;
    end
  end

  // ack is held while the enable is low, as is all other state
  assign cfg_ack_o = (ans_reg == PCR_ANS_DONE);
  assign cfg_rdata_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_rd_take(logic sel);
    cfg_req_i && ce_i && !cfg_we_i && sel;
  endsequence

  sequence s_wr_take(logic sel);
    cfg_req_i && ce_i && cfg_we_i && sel;
  endsequence

  sequence s_answer;
    cfg_ack_o;
  endsequence

  // clear and event in one cycle: the event must win
  sequence s_clear_with_event;
    flag_clr && det_evt_i;
  endsequence

  AST_RSVD_ZERO: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RQ1
    s_rd_take(cfg.sel_rsvd) |=> s_answer and (cfg_rdata_o == ZERO_WORD))
    else $error("reserved dword read non-zero");

  AST_LAT_FIELD: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RQ2
    s_rd_take(cfg.sel_intr) |=> cfg_rdata_o[31:24] == 8'h0f)
    else $error("latency field wrong");

  AST_GNT_FIELD: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RQ3
    s_rd_take(cfg.sel_intr) |=> cfg_rdata_o[23:16] == 8'h00)
    else $error("grant field not zero");

  AST_PIN_FIELD: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RQ4
    s_rd_take(cfg.sel_intr) |=> cfg_rdata_o[15:8] == 8'h01)
    else $error("interrupt pin field wrong");

  AST_LINE_WRITE: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RQ5
    s_wr_take(cfg.sel_intr && cfg_be_i[0]) |=> line_val == $past(cfg_wdata_i[7:0]))
    else $error("routing byte not stored");

  AST_DEP_ZERO: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RQ6
    s_rd_take(cfg_addr_i >= 8'h40) |=> cfg_rdata_o == ZERO_WORD)
    else $error("device-dependent region read non-zero");

  AST_RO_STABLE: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RQ7
    s_wr_take(!cfg.sel_intr && !cfg.sel_stat) |=> $stable(line_val) && $stable(det_flag_o) || $past(det_evt_i))
    else $error("write changed read-only state");

  AST_FLAG_CLEAR: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RQ8
    flag_clr && !det_evt_i |=> !det_flag_o)
    else $error("flag not cleared by write one");

  AST_FLAG_KEEP: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RQ8
    s_wr_take(cfg.sel_stat && !cfg_wdata_i[31] && det_flag_o) |=> det_flag_o)
    else $error("flag lost on write zero");

  AST_LINE_READBACK: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RQ9
    s_wr_take(cfg.sel_intr && cfg_be_i[0]) ##1 s_rd_take(cfg.sel_intr) |=> cfg_rdata_o[7:0] == $past(cfg_wdata_i[7:0], 2))
    else $error("routing byte readback differs");

  AST_F1_ZERO: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RQ10
    s_rd_take(cfg_func_i && cfg_addr_i[7:2] > 6'd1 && cfg_addr_i[7:2] < 6'd16) |=> cfg_rdata_o == ZERO_WORD)
    else $error("unused second-function dword non-zero");

  AST_ID_WORD: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RQ11
    s_rd_take(cfg.sel_id) |=> cfg_rdata_o == ID_WORD)
    else $error("identification word wrong");

  AST_ID_SHARED: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RQ13
    s_rd_take(cfg.sel_id && !cfg_func_i) ##1 s_rd_take(cfg.sel_id && cfg_func_i) |=> $stable(cfg_rdata_o))
    else $error("identification differs between functions");

  AST_ACK_TIMING: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RQ14
    cfg_req_i && ce_i |=> s_answer ##1 (cfg_ack_o == $past(cfg_req_i) || !$past(ce_i)))
    else $error("answer not in data phase");

  AST_FLAG_SET_WINS: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RQ8
    s_clear_with_event |=> det_flag_o)
    else $error("clear beat a same-cycle event");

  AST_STAT_UNUSED: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RQ7
    s_rd_take(cfg.sel_stat) |=> cfg_rdata_o[30:0] == 31'h0)
    else $error("unused status bits non-zero");

  AST_LINE_KEEP: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RQ9
    s_wr_take(cfg.sel_intr && !cfg_be_i[0]) |=> $stable(line_val))
    else $error("routing byte changed without its lane");

  AST_DEV_DIGIT: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RQ11
    s_rd_take(cfg.sel_id) |=> cfg_rdata_o[31:20] == DEV_ID_HI && $onehot(cfg_rdata_o[19:16]))
    else $error("device code malformed");

  AST_VENDOR_FIELD: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RQ12
    s_rd_take(cfg.sel_id) |=> cfg_rdata_o[15:0] == VENDOR_ID)
    else $error("vendor code wrong");

  AST_WR_ANSWER: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RQ14
    s_wr_take(1'b1) |=> s_answer and (cfg_rdata_o == ZERO_WORD))
    else $error("write answer not zero");

  AST_NO_TAKE_IDLE: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RQ14
    ce_i && !cfg_req_i |=> !cfg_ack_o)
    else $error("answer without a request");

  // enable low is a full stall: no answer may fall and no stored bit may move
  AST_ENABLE_FREEZE: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RQ14
    !ce_i |=> $stable(cfg_ack_o) && $stable(cfg_rdata_o) && $stable(det_flag_o) && $stable(line_val))
    else $error("state moved with enable low");

endmodule

// ==== testbench/pcr_host_model.sv ====
/*
  Behavioural configuration-cycle master standing in front of the register bank.
  Assumes the bank answers exactly one clock after it takes a one-cycle request.
*/
`timescale 1ns/10ps
module pcr_host_model (
  // clock and answer
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] rdata_i,
  // request
  output logic req_o,
  output logic we_o,
  output logic func_o,
  output logic [7:0] addr_o,
  output logic [3:0] be_o,
  output logic [31:0] wdata_o
);
  initial begin
    req_o = 1'b0;
    we_o = 1'b0;
    func_o = 1'b0;
    addr_o = 8'h00;
    be_o = 4'h0;
    wdata_o = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one dword per cycle
  // released address, byte enables and write data are inverted so a stale value can never pass for a held one
  task automatic cycle(input logic we, input logic f, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] wd, output logic ack, output logic [31:0] rd);
    @(posedge clk_i);
    #1;
    we_o = we;
    func_o = f;
    addr_o = a;
    be_o = be;
    wdata_o = wd;
    req_o = 1'b1;
    @(posedge clk_i);
    #1;
    req_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~wd;
    be_o = ~be;
    ack = ack_i;
    rd = rdata_i;
  endtask

  // back-to-back pair, the first may be a write, the second is a read
  task automatic pair(input logic we0, input logic f0, input logic [7:0] a0, input logic [3:0] be0,
                      input logic [31:0] wd0, input logic f1, input logic [7:0] a1,
                      output logic ack0, output logic [31:0] rd0, output logic ack1, output logic [31:0] rd1);
    @(posedge clk_i);
    #1;
    we_o = we0;
    func_o = f0;
    addr_o = a0;
    be_o = be0;
    wdata_o = wd0;
    req_o = 1'b1;
    @(posedge clk_i);
    #1;
    we_o = 1'b0;
    func_o = f1;
    addr_o = a1;
    wdata_o = ~wd0;
    ack0 = ack_i;
    rd0 = rdata_i;
    @(posedge clk_i);
    #1;
    req_o = 1'b0;
    addr_o = ~a1;
    ack1 = ack_i;
    rd1 = rdata_i;
  endtask
endmodule

// ==== testbench/pcr_cfg_regs_test.sv ====
/*
  Self-checking bench for the configuration header register bank.
  Assumes the host model drives every cycle and the bank runs at 125 MHz.
*/
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin fails++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module pcr_cfg_regs_test;
  import pcr_pkg::*;

  typedef struct {
    logic f;
    logic [7:0] a;
    logic [3:0] be;
    logic [31:0] wd;
    logic [31:0] ex;
  } pcr_row_t;

  // arbitrary identity values; 64 channels selects digit 2
  localparam logic [11:0] DEV_HI = 12'h5a3;
  localparam logic [15:0] VEND = 16'h0a5c;
  localparam logic [31:0] ID_EXP = {DEV_HI, 4'h2, VEND};
  localparam logic [23:0] FIX_HI = {MAX_LAT_VAL, MIN_GNT_VAL, INT_PIN_VAL};

  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic det_evt_i = 1'b0;
  logic cfg_req_i, cfg_we_i, cfg_func_i, cfg_ack_o, det_flag_o;
  logic [7:0] cfg_addr_i;
  logic [3:0] cfg_be_i;
  logic [31:0] cfg_wdata_i, cfg_rdata_o;
  int fails = 0;
  int num_checks = 0;
  logic ack, ack2;
  logic [31:0] rd, rd2;

  // rows: write, then read back the same dword
  pcr_row_t rows [10] = '{
    '{1'b0, 8'h14, 4'hf, 32'hffff_ffff, ZERO_WORD},
    '{1'b0, 8'h38, 4'hf, 32'hffff_ffff, ZERO_WORD},
    '{1'b0, 8'h3c, 4'hf, 32'hffff_ffff, {FIX_HI, 8'hff}},
    '{1'b0, 8'h3c, 4'h1, 32'h0000_005a, {FIX_HI, 8'h5a}},
    '{1'b0, 8'h3c, 4'he, 32'hffff_ffa5, {FIX_HI, 8'h5a}},
    '{1'b0, 8'h40, 4'hf, 32'hffff_ffff, ZERO_WORD},
    '{1'b1, 8'hfc, 4'hf, 32'hffff_ffff, ZERO_WORD},
    '{1'b0, 8'h00, 4'hf, 32'hffff_ffff, ID_EXP},
    '{1'b1, 8'h00, 4'hf, 32'h0000_0000, ID_EXP},
    '{1'b1, 8'h3c, 4'hf, 32'hffff_ffff, ZERO_WORD}
  };

  always #4 mclk_i = ~mclk_i;

  pcr_cfg_regs #(.CHAN_COUNT(64), .DEV_ID_HI(DEV_HI), .VENDOR_ID(VEND)) DUT (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .cfg_req_i(cfg_req_i), .cfg_we_i(cfg_we_i),
    .cfg_func_i(cfg_func_i), .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_ack_o(cfg_ack_o), .cfg_rdata_o(cfg_rdata_o), .det_evt_i(det_evt_i), .det_flag_o(det_flag_o));

  pcr_host_model host (
    .clk_i(mclk_i), .ack_i(cfg_ack_o), .rdata_i(cfg_rdata_o), .req_o(cfg_req_i), .we_o(cfg_we_i),
    .func_o(cfg_func_i), .addr_o(cfg_addr_i), .be_o(cfg_be_i), .wdata_o(cfg_wdata_i));

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic f, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    host.cycle(1'b1, f, a, be, d, ack, rd);
    `CHK("write ack", 1'b1, ack)
    `CHK("write rdata", ZERO_WORD, rd)
  endtask

  task automatic rdc(input logic f, input logic [7:0] a, input logic [31:0] ex);
    host.cycle(1'b0, f, a, 4'h0, 32'h0, ack, rd);
    `CHK("read ack", 1'b1, ack)
    `CHK("read data", ex, rd)
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge mclk_i);
    #1;
    arst_n_i = 1'b1;
    `CHK("ack after reset", 1'b0, cfg_ack_o)
    `CHK("flag after reset", 1'b0, det_flag_o)
    rdc(1'b0, 8'h3c, {FIX_HI, INT_LINE_RST});
    foreach (rows[i]) begin
      wr(rows[i].f, rows[i].a, rows[i].be, rows[i].wd);
      rdc(rows[i].f, rows[i].a, rows[i].ex);
    end
    // back-to-back: ack must stay high across both answers
    host.pair(1'b0, 1'b0, 8'h3c, 4'h0, ZERO_WORD, 1'b0, 8'h00, ack, rd, ack2, rd2);
    `CHK("first of pair", {1'b1, FIX_HI, 8'h5a}, {ack, rd})
    `CHK("second of pair", {1'b1, ID_EXP}, {ack2, rd2})
    // identification from both functions back to back
    host.pair(1'b0, 1'b0, 8'h00, 4'h0, ZERO_WORD, 1'b1, 8'h00, ack, rd, ack2, rd2);
    `CHK("id from first function", {1'b1, ID_EXP}, {ack, rd})
    `CHK("id from second function", {1'b1, ID_EXP}, {ack2, rd2})
    // write, then read it in the very next cycle
    host.pair(1'b1, 1'b0, 8'h3c, 4'h1, 32'h0000_00c3, 1'b0, 8'h3c, ack, rd, ack2, rd2);
    `CHK("write of pair", {1'b1, ZERO_WORD}, {ack, rd})
    `CHK("readback of pair", {1'b1, FIX_HI, 8'hc3}, {ack2, rd2})
    // enable low holds the standing answer and takes neither request nor event
    ce_i = 1'b0;
    det_evt_i = 1'b1;
    host.cycle(1'b1, 1'b0, 8'h3c, 4'h1, 32'h0000_0077, ack, rd);
    `CHK("frozen answer", {1'b1, FIX_HI, 8'hc3}, {ack, rd})
    `CHK("flag with enable low", 1'b0, det_flag_o)
    det_evt_i = 1'b0;
    ce_i = 1'b1;
    rdc(1'b0, 8'h3c, {FIX_HI, 8'hc3});
    @(posedge mclk_i);
    #1;
    det_evt_i = 1'b1;
    @(posedge mclk_i);
    #1;
    det_evt_i = 1'b0;
    `CHK("flag set", 1'b1, det_flag_o)
    rdc(1'b1, 8'h04, 32'h8000_0000);
    wr(1'b1, 8'h04, 4'h8, 32'h0000_0000);
    `CHK("flag kept on zero", 1'b1, det_flag_o)
    wr(1'b1, 8'h04, 4'h7, 32'h8000_0000);
    `CHK("flag kept off lane", 1'b1, det_flag_o)
    wr(1'b1, 8'h04, 4'h8, 32'h8000_0000);
    `CHK("flag cleared", 1'b0, det_flag_o)
    rdc(1'b1, 8'h04, ZERO_WORD);
    // an event in the clearing cycle wins over the clear
    fork
      wr(1'b1, 8'h04, 4'h8, 32'h8000_0000);
      begin
        @(posedge mclk_i);
        #1;
        det_evt_i = 1'b1;
        @(posedge mclk_i);
        #1;
        det_evt_i = 1'b0;
      end
    join
    `CHK("set wins over clear", 1'b1, det_flag_o)
    rdc(1'b0, 8'h3c, {FIX_HI, 8'hc3});
    // a fresh reset must clear the flag, the answer and the routing byte
    arst_n_i = 1'b0;
    @(posedge mclk_i);
    #1;
    arst_n_i = 1'b1;
    `CHK("answer after reset", {1'b0, ZERO_WORD}, {cfg_ack_o, cfg_rdata_o})
    `CHK("flag after second reset", 1'b0, det_flag_o)
    rdc(1'b0, 8'h3c, {FIX_HI, INT_LINE_RST});
    summarize();
  end

  // about 37 transfers at 2 cycles or less each fit well inside this span
  initial begin
    #20000;
    fails++;
    summarize();
  end
endmodule
